// [core/frc_host.sv]
`timescale 1ns/1ns
`default_nettype none
// Host controller driving a parallel boot-sector flash through its pins.
module frc_host
    import frc_pkg::*;
#(
    parameter int RP = RP_CYC,
    parameter int RH = RH_CYC,
    parameter int BUSY_MAX = 4000
) (
    input  wire logic              sys_clk,      // 100 MHz clock
    input  wire logic              rst_n,        // Sync reset, active low
    input  wire logic              reqValid,     // Request strobe
    input  wire logic [2:0]        reqOp,        // Request kind, frc_op_e
    input  wire logic [ADDR_W-1:0] reqAddr,      // Request address
    input  wire logic [DATA_W-1:0] reqData,      // Program data
    output logic                   reqReady,     // Idle, request may be given
    output logic                   rspValid,     // Answer pulse
    output logic [DATA_W-1:0]      rspData,      // Read answer
    output logic                   rspTimeout,   // Busy wait expired
    output logic                   flashCeN,     // Chip select pin
    output logic                   flashOeN,     // Output gate pin
    output logic                   flashWeN,     // Write strobe pin
    output logic                   flashResetN,  // Reset pin
    output logic [ADDR_W-1:0]      flashAddr,    // Address pins
    output logic [DATA_W-1:0]      flashDqOut,   // Data pin drive
    output logic                   flashDqOe,    // Data pin enable
    input  wire logic [DATA_W-1:0] flashDqIn,    // Data pin level
    input  wire logic              done_busy_n   // Ready pin, low busy
);
    typedef enum logic [2:0] {
        FRC_IDLE   = 3'h0,
        FRC_SEQ    = 3'h1,
        FRC_BUSY   = 3'h2,
        FRC_RSTLOW = 3'h3,
        FRC_RSTREC = 3'h4,
        FRC_DONE   = 3'h5
    } frc_st_e;

    logic [DATA_W-1:0] dq1_r, dqS_r;
    logic rb1_r, rbS_r;
    always_ff @(posedge sys_clk) begin
        dq1_r <= flashDqIn;
        dqS_r <= dq1_r;
        rb1_r <= done_busy_n;
        rbS_r <= rb1_r;
    end

    frc_st_e st_r, st_nxt;
    frc_op_e op_r, op_nxt;
    logic [2:0] step_r, step_nxt, nSteps;
    logic [ADDR_W-1:0] addr_r, addr_nxt;
    logic [DATA_W-1:0] data_r, data_nxt, rsp_r, rsp_nxt;
    logic [15:0] cnt_r, cnt_nxt;
    logic rdy_r, rdy_nxt, rv_r, rv_nxt, to_r, to_nxt, rst_r, rst_nxt, issued_r, issued_nxt;
    logic bcStart, bcWrite, bcDone;
    logic [ADDR_W-1:0] bcAddr;
    logic [DATA_W-1:0] bcData, bcRd;

    // Command step table: address and data of each bus cycle
    // R15 no unprotect cycle is ever issued, so protect-first order holds
    always_comb begin
        bcWrite = 1'b1;
        bcAddr = {8'h00, UNLOCK_A1};
        bcData = UNLOCK_D1;
        nSteps = 3'h1;
        unique case (op_r)
            FRC_OP_READ: begin
                nSteps = 3'h1;
                bcWrite = 1'b0;
                bcAddr = addr_r;
            end
            // R25 leave identifier mode
            FRC_OP_RST: begin
                nSteps = 3'h1;
                bcData = CMD_RESET;
            end
            // R24 identifier read at low address
            FRC_OP_IDRD: begin
                nSteps = 3'h5;
                if (step_r == 3'h1) begin bcAddr = {8'h00, UNLOCK_A2}; bcData = UNLOCK_D2; end
                if (step_r == 3'h2) bcData = CMD_AUTOSEL;
                if (step_r == 3'h3) begin bcWrite = 1'b0; bcAddr = addr_r; end
                if (step_r == 3'h4) bcData = CMD_RESET;
            end
            // R17 unlock cycles precede program
            FRC_OP_PROG: begin
                nSteps = 3'h4;
                if (step_r == 3'h1) begin bcAddr = {8'h00, UNLOCK_A2}; bcData = UNLOCK_D2; end
                if (step_r == 3'h2) bcData = CMD_PROGRAM;
                if (step_r == 3'h3) begin bcAddr = addr_r; bcData = data_r; end
            end
            default: begin
                // R17 six-cycle erase sequence
                nSteps = 3'h6;
                if (step_r == 3'h1 || step_r == 3'h4) begin bcAddr = {8'h00, UNLOCK_A2}; bcData = UNLOCK_D2; end
                if (step_r == 3'h2) bcData = CMD_ERASE;
                if (step_r == 3'h5) begin
                    bcAddr = (op_r == FRC_OP_SERA) ? addr_r : {8'h00, UNLOCK_A1};
                    bcData = (op_r == FRC_OP_SERA) ? CMD_SECTOR : CMD_CHIP;
                end
            end
        endcase
    end

    always_comb begin
        st_nxt = st_r; op_nxt = op_r; step_nxt = step_r; addr_nxt = addr_r; data_nxt = data_r;
        rsp_nxt = rsp_r; cnt_nxt = cnt_r; rdy_nxt = 1'b0; rv_nxt = 1'b0; to_nxt = to_r;
        rst_nxt = rst_r; issued_nxt = 1'b0; bcStart = 1'b0;
        unique case (st_r)
            FRC_IDLE: begin
                rdy_nxt = 1'b1;
                if (reqValid && rdy_r) begin
                    op_nxt = frc_op_e'(reqOp);
                    addr_nxt = reqAddr;
                    data_nxt = reqData;
                    step_nxt = '0;
                    to_nxt = 1'b0;
                    rdy_nxt = 1'b0;
                    if (frc_op_e'(reqOp) == FRC_OP_HWRST) begin
                        rst_nxt = 1'b0;
                        cnt_nxt = 16'(RP);
                        st_nxt = FRC_RSTLOW;
                    end else begin
                        st_nxt = FRC_SEQ;
                    end
                end
            end
            FRC_SEQ: begin
                bcStart = !issued_r;
                issued_nxt = !bcDone;
                if (bcDone) begin
                    if (!bcWrite) rsp_nxt = bcRd;
                    if (step_r == nSteps - 3'h1) begin
                        cnt_nxt = 16'(BUSY_MAX);
                        st_nxt = (op_r == FRC_OP_PROG || op_r == FRC_OP_SERA || op_r == FRC_OP_CERA)
                                 ? FRC_BUSY : FRC_DONE;
                    end else begin
                        step_nxt = step_r + 3'h1;
                    end
                end
            end
            // Waits on the ready pin with a bound, pin starts low after a few ns
            FRC_BUSY: begin
                cnt_nxt = cnt_r - 16'h0001;
                if (rbS_r && cnt_r < 16'(BUSY_MAX - 8)) st_nxt = FRC_DONE;
                else if (cnt_r == 16'h0000) begin to_nxt = 1'b1; st_nxt = FRC_DONE; end
            end
            FRC_RSTLOW: begin
                cnt_nxt = cnt_r - 16'h0001;
                if (cnt_r <= 16'h0001) begin
                    rst_nxt = 1'b1;
                    cnt_nxt = 16'(RH);
                    st_nxt = FRC_RSTREC;
                end
            end
            // R7 recovery before any read; R4 caller restarts interrupted work
            FRC_RSTREC: begin
                // Parks at zero so a slow ready pin cannot wrap the count
                if (cnt_r != 16'h0000) cnt_nxt = cnt_r - 16'h0001;
                if (cnt_r <= 16'h0001 && rbS_r) st_nxt = FRC_DONE;
            end
            FRC_DONE: begin
                rv_nxt = 1'b1;
                st_nxt = FRC_IDLE;
            end
            default: st_nxt = FRC_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            st_r <= FRC_IDLE; op_r <= FRC_OP_READ; step_r <= '0; addr_r <= '0; data_r <= '0;
            rsp_r <= '0; cnt_r <= '0; rdy_r <= 1'b0; rv_r <= 1'b0; to_r <= 1'b0;
            rst_r <= 1'b1; issued_r <= 1'b0;
        end else begin
            st_r <= st_nxt; op_r <= op_nxt; step_r <= step_nxt; addr_r <= addr_nxt; data_r <= data_nxt;
            rsp_r <= rsp_nxt; cnt_r <= cnt_nxt; rdy_r <= rdy_nxt; rv_r <= rv_nxt; to_r <= to_nxt;
            rst_r <= rst_nxt; issued_r <= issued_nxt;
        end
    end

    frc_bus_cycle u_bc (
        .sys_clk  (sys_clk),
        .rst_n    (rst_n),
        .start    (bcStart),
        .isWrite  (bcWrite),
        .addr     (bcAddr),
        .wdata    (bcData),
        .dqInSync (dqS_r),
        .ceN      (flashCeN),
        .oeN      (flashOeN),
        .weN      (flashWeN),
        .aOut     (flashAddr),
        .dqOut    (flashDqOut),
        .dqOe     (flashDqOe),
        .rdata    (bcRd),
        .done     (bcDone)
    );

    assign reqReady = rdy_r;
    assign rspValid = rv_r;
    assign rspData = rsp_r;
    assign rspTimeout = to_r;
    assign flashResetN = rst_r;

    // R20 host never writes with output gate low
    write_levels_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R20
        !flashWeN |-> (!flashCeN && flashOeN && flashDqOe))
        else $error("write strobe low without proper gate levels");
    // R7 first access waits for recovery after reset release
    reset_recovery_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R7
        $rose(flashResetN) |-> flashCeN [*5])
        else $error("access started inside reset recovery");
    reset_quiet_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R7
        !flashResetN |-> flashCeN)
        else $error("bus cycle during reset pulse");
    // R1 reset held low at least 8 cycles
    reset_width_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R1
        $fell(flashResetN) |-> !flashResetN [*8])
        else $error("reset pulse too short");
    // R20 no write or data drive during read
    read_levels_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R20
        !flashOeN |-> (flashWeN && !flashDqOe))
        else $error("data driven while output gate low");
    cover_reset_c: cover property (@(posedge sys_clk) disable iff (!rst_n) $rose(flashResetN));
    cover_write_c: cover property (@(posedge sys_clk) disable iff (!rst_n) $fell(flashWeN));
    cover_read_c: cover property (@(posedge sys_clk) disable iff (!rst_n) $fell(flashOeN));
    cover_busy_c: cover property (@(posedge sys_clk) disable iff (!rst_n) st_r == FRC_BUSY && rbS_r);
endmodule
`default_nettype wire

// [core/frc_pkg.sv]
// Overview of operation
// R1 - Device aborts any operation when reset held low the minimum time.
// R2 - During reset device tristates data and ignores reads and writes.
// R3 - Reset returns device state machine to array read.
// R4 - Host restarts any program or erase that a reset interrupted.
// R5 - Reset during program or erase keeps done_busy_n low until finished.
// R6 - Reset while idle completes within the shorter ready time.
// R7 - Host waits reset-high recovery time before first read.
// R8 - Top-boot sector decode from address bits 18 to 13.
// R9 - Bottom-boot sector decode from address bits 18 to 13.
// R10 - Identifier codes reachable in-system and by high-voltage pin method. The model reaches them in-system only.
// R11 - Pin method enters identifier readout with elevated voltage on address pin 9. The model has no pin method.
// R12 - Address bits 1 and 0 select maker, device, continuation or protection code.
// R13 - Protection read returns 01h if protected, else 00h.
// R14 - Protected sector rejects program and erase.
// R15 - Host protects all unprotected sectors before first unprotect cycle.
// R16 - Device ships with all sectors unprotected.
// R17 - Program and erase need the multi-cycle unlock sequence.
// R18 - Strobe pulses under about 5ns start no write.
// R19 - Writes inhibited when output gate low, chip select high or write strobe high.
// R20 - Host writes with chip select and write strobe low, output gate high.
// R21 - No command accepted on strobe edge after power-up with write asserted.
// R22 - Device powers up in array read.
// R23 - Address latched on later falling edge, data on earlier rising edge.
// R24 - In-system identifier reads at 00h, 01h, 03h, and 02h with sector.
// R25 - Host writes reset command to leave identifier mode.
// R26 - Device keeps one protection flag per sector, checked before program or erase.
package frc_pkg;
    localparam int ADDR_W = 19;
    localparam int DATA_W = 8;
    // Pin timing, ns
    localparam int CLK_NS      = 10;
    localparam int T_RP_NS     = 500;
    localparam int T_RH_NS     = 50;
    localparam int T_WP_NS     = 40;
    localparam int T_RD_NS     = 70;
    localparam int RP_CYC      = (T_RP_NS + CLK_NS - 1) / CLK_NS;
    localparam int RH_CYC      = (T_RH_NS + CLK_NS - 1) / CLK_NS;
    localparam int WP_CYC      = (T_WP_NS + CLK_NS - 1) / CLK_NS;
    localparam int RD_CYC      = (T_RD_NS + CLK_NS - 1) / CLK_NS;
    localparam int CNT_W       = 8;
    // Command cycle addresses and data
    localparam logic [10:0] UNLOCK_A1 = 11'h555;
    localparam logic [10:0] UNLOCK_A2 = 11'h2AA;
    localparam logic [7:0]  UNLOCK_D1 = 8'hAA;
    localparam logic [7:0]  UNLOCK_D2 = 8'h55;
    localparam logic [7:0]  CMD_AUTOSEL = 8'h90;
    localparam logic [7:0]  CMD_PROGRAM = 8'hA0;
    localparam logic [7:0]  CMD_ERASE   = 8'h80;
    localparam logic [7:0]  CMD_SECTOR  = 8'h30;
    localparam logic [7:0]  CMD_CHIP    = 8'h10;
    localparam logic [7:0]  CMD_RESET   = 8'hF0;
    // Identifier read low addresses
    localparam logic [1:0] ID_MAKER = 2'h0;
    localparam logic [1:0] ID_DEV   = 2'h1;
    localparam logic [1:0] ID_PROT  = 2'h2;
    localparam logic [1:0] ID_CONT  = 2'h3;
    localparam logic [7:0] PROT_YES = 8'h01;
    localparam logic [7:0] PROT_NO  = 8'h00;
    localparam int NUM_SECT = 11;
    // Host request kinds
    typedef enum logic [2:0] {
        FRC_OP_READ  = 3'h0,
        FRC_OP_PROG  = 3'h1,
        FRC_OP_SERA  = 3'h2,
        FRC_OP_CERA  = 3'h3,
        FRC_OP_IDRD  = 3'h4,
        FRC_OP_RST   = 3'h5,
        FRC_OP_HWRST = 3'h6
    } frc_op_e;
endpackage

// [core/frc_bus_cycle.sv]
`timescale 1ns/1ns
`default_nettype none
// One flash bus cycle; write data stays driven past the strobe rise.
module frc_bus_cycle
    import frc_pkg::*;
#(
    parameter int WP = WP_CYC,
    parameter int RD = RD_CYC
) (
    input  wire logic              sys_clk,    // Clock
    input  wire logic              rst_n,      // Sync reset
    input  wire logic              start,      // Begin cycle
    input  wire logic              isWrite,    // Write when high
    input  wire logic [ADDR_W-1:0] addr,       // Cycle address
    input  wire logic [DATA_W-1:0] wdata,      // Write data
    input  wire logic [DATA_W-1:0] dqInSync,   // Synchronised data pins
    output logic                   ceN,        // Chip select
    output logic                   oeN,        // Output gate
    output logic                   weN,        // Write strobe
    output logic [ADDR_W-1:0]      aOut,       // Address pins
    output logic [DATA_W-1:0]      dqOut,      // Data drive
    output logic                   dqOe,       // Data drive enable
    output logic [DATA_W-1:0]      rdata,      // Read result
    output logic                   done        // Cycle finished pulse
);
    typedef enum logic [1:0] {
        FRC_BC_IDLE = 2'h0,
        FRC_BC_ACT  = 2'h1,
        FRC_BC_HOLD = 2'h2
    } frc_bc_e;
    frc_bc_e st_r, st_nxt;
    logic [CNT_W-1:0] cnt_r, cnt_nxt;
    logic ce_r, ce_nxt, oe_r, oe_nxt, we_r, we_nxt, dqOe_r, dqOe_nxt, done_r, done_nxt;
    logic [ADDR_W-1:0] a_r, a_nxt;
    logic [DATA_W-1:0] dq_r, dq_nxt, rd_r, rd_nxt;
    always_comb begin
        st_nxt = st_r; cnt_nxt = cnt_r; ce_nxt = ce_r; oe_nxt = oe_r; we_nxt = we_r;
        dqOe_nxt = dqOe_r; done_nxt = 1'b0; a_nxt = a_r; dq_nxt = dq_r; rd_nxt = rd_r;
        unique case (st_r)
            FRC_BC_IDLE: if (start) begin
                a_nxt = addr;
                dq_nxt = wdata;
                ce_nxt = 1'b0;
                // R20 write levels
                oe_nxt = isWrite;
                we_nxt = !isWrite;
                dqOe_nxt = isWrite;
                // R18 strobe kept well past glitch width
                cnt_nxt = CNT_W'(isWrite ? WP : RD);
                st_nxt = FRC_BC_ACT;
            end
            FRC_BC_ACT: if (cnt_r <= CNT_W'(1)) begin
                if (!oe_r) rd_nxt = dqInSync;
                // R23 data taken on strobe rise
                we_nxt = 1'b1;
                oe_nxt = 1'b1;
                st_nxt = FRC_BC_HOLD;
            end else begin
                cnt_nxt = cnt_r - CNT_W'(1);
            end
            FRC_BC_HOLD: begin
                ce_nxt = 1'b1;
                dqOe_nxt = 1'b0;
                done_nxt = 1'b1;
                st_nxt = FRC_BC_IDLE;
            end
            default: st_nxt = FRC_BC_IDLE;
        endcase
    end
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            st_r <= FRC_BC_IDLE; cnt_r <= '0; ce_r <= 1'b1; oe_r <= 1'b1; we_r <= 1'b1;
            dqOe_r <= 1'b0; done_r <= 1'b0; a_r <= '0; dq_r <= '0; rd_r <= '0;
        end else begin
            st_r <= st_nxt; cnt_r <= cnt_nxt; ce_r <= ce_nxt; oe_r <= oe_nxt; we_r <= we_nxt;
            dqOe_r <= dqOe_nxt; done_r <= done_nxt; a_r <= a_nxt; dq_r <= dq_nxt; rd_r <= rd_nxt;
        end
    end
    assign ceN = ce_r;
    assign oeN = oe_r;
    assign weN = we_r;
    assign aOut = a_r;
    assign dqOut = dq_r;
    assign dqOe = dqOe_r;
    assign rdata = rd_r;
    assign done = done_r;
endmodule
`default_nettype wire

// [sim/frc_flash_model.sv]
`timescale 1ns/1ns
`default_nettype none
// Behavioural boot-sector flash on the far side of the host pins.
module frc_flash_model
    import frc_pkg::*;
#(
    parameter bit          TOP_BOOT = 1'b1,
    parameter logic [7:0]  MAKER_ID = 8'h5A,  // Arbitrary value
    parameter logic [7:0]  DEV_ID   = 8'hC3,  // Arbitrary value
    parameter logic [7:0]  CONT_ID  = 8'h66,  // Arbitrary value
    parameter int          RDY_NS   = 200
) (
    input  wire logic              ceN,        // Chip select
    input  wire logic              oeN,        // Output gate
    input  wire logic              weN,        // Write strobe
    input  wire logic              resetN,     // Reset pin
    input  wire logic [ADDR_W-1:0] addr,       // Address pins
    input  wire logic [DATA_W-1:0] dqIn,       // Data wire level
    input  wire logic [10:0]       protMask,   // Per-sector protect flags
    input  wire logic [15:0]       busyNs,     // Embedded op length
    output logic [DATA_W-1:0]      dqOut,      // Read drive
    output logic                   dqOe,       // Read drive enable
    output logic                   doneBusyN   // Low while busy
);
    logic [7:0]        mem [0:(1<<ADDR_W)-1];
    logic [ADDR_W-1:0] wAddr;
    logic [ADDR_W-1:0] opAddr;
    logic [7:0]        opData;
    logic [3:0]        step;
    logic              idMode;
    int                opKind;
    int                busyLeft = 0;
    time               tFall;
    wire               wrAct = !ceN && !weN && oeN && resetN;

    function automatic int sect(input logic [ADDR_W-1:0] a);
        if (TOP_BOOT) begin
            if (a[18:16] != 3'h7) return int'(a[18:16]);
            if (!a[15]) return 7;
            if (a[14]) return 10;
            return a[13] ? 9 : 8;
        end
        if (a[18:16] != 3'h0) return int'(a[18:16]) + 3;
        if (a[15]) return 3;
        if (!a[14]) return 0;
        return a[13] ? 2 : 1;
    endfunction

    initial begin
        step = 4'h0;
        idMode = 1'b0;
        for (int i = 0; i < (1 << ADDR_W); i++) mem[i] = 8'hFF;
    end

    task automatic startOp(input int k, input logic [ADDR_W-1:0] a, input logic [7:0] d);
        if (k != 3 && protMask[sect(a)]) return;
        opKind = k;
        opAddr = a;
        opData = d;
        busyLeft = busyNs;
    endtask

    task automatic finishOp();
        busyLeft = 0;
        if (opKind == 1) mem[opAddr] = mem[opAddr] & opData;
        if (opKind >= 2) begin
            for (int i = 0; i < (1 << ADDR_W); i++) begin
                if (opKind == 3 ? !protMask[sect(ADDR_W'(i))] : sect(ADDR_W'(i)) == sect(opAddr)) mem[i] = 8'hFF;
            end
        end
        opKind = 0;
    endtask

    always @(posedge wrAct) begin
        tFall = $time;
        // Address pins change in the same step as the strobes
        #1 wAddr = addr;
    end

    // unlock sequence, data on rise; no seen fall, no command
    always @(negedge wrAct) begin
        if ($time - tFall >= 5 && busyLeft == 0) begin
            if (dqIn == CMD_RESET) begin
                step = 4'h0;
                idMode = 1'b0;
            end else begin
                case (step)
                    4'h0, 4'h4: step = (wAddr[10:0] == UNLOCK_A1 && dqIn == UNLOCK_D1) ? step + 4'h1 : 4'h0;
                    4'h1, 4'h5: step = (wAddr[10:0] == UNLOCK_A2 && dqIn == UNLOCK_D2) ? step + 4'h1 : 4'h0;
                    4'h2: begin
                        step = 4'h0;
                        if (wAddr[10:0] == UNLOCK_A1 && dqIn == CMD_AUTOSEL) idMode = 1'b1;
                        if (wAddr[10:0] == UNLOCK_A1 && dqIn == CMD_PROGRAM) step = 4'h3;
                        if (wAddr[10:0] == UNLOCK_A1 && dqIn == CMD_ERASE) step = 4'h4;
                    end
                    4'h3: begin
                        step = 4'h0;
                        startOp(1, wAddr, dqIn);
                    end
                    default: begin
                        step = 4'h0;
                        if (dqIn == CMD_SECTOR) startOp(2, wAddr, dqIn);
                        if (dqIn == CMD_CHIP && wAddr[10:0] == UNLOCK_A1) startOp(3, wAddr, dqIn);
                    end
                endcase
            end
        end
    end

    always #10 begin
        if (busyLeft > 0) begin
            busyLeft = busyLeft - 10;
            if (busyLeft <= 0) finishOp();
        end
    end

    always @(negedge resetN) begin
        step = 4'h0;
        idMode = 1'b0;
        if (busyLeft > 0) begin
            opKind = 0;
            busyLeft = RDY_NS;
        end
    end

    assign doneBusyN = (busyLeft == 0);
    // drive only on a clean read
    assign dqOe = !ceN && !oeN && weN && resetN;

    always_comb begin
        dqOut = mem[addr];
        if (idMode) begin
            case (addr[1:0])
                ID_MAKER: dqOut = MAKER_ID;
                ID_DEV:   dqOut = DEV_ID;
                ID_CONT:  dqOut = CONT_ID;
                default:  dqOut = protMask[sect(addr)] ? PROT_YES : PROT_NO;
            endcase
        end
    end
endmodule
`default_nettype wire

// [sim/flash_reset_protect_autoselect_test.sv]
`timescale 1ns/1ns
`default_nettype none
module flash_reset_protect_autoselect_test;
    import frc_pkg::*;
    localparam logic [7:0] MK = 8'h5A;  // Arbitrary value
    localparam logic [7:0] DV = 8'hC3;  // Arbitrary value
    localparam logic [7:0] CT = 8'h66;  // Arbitrary value
    logic              sysClk, rstN, reqValid, reqReady, rspValid, rspTimeout;
    logic [2:0]        reqOp;
    logic [ADDR_W-1:0] reqAddr, fAddr;
    logic [DATA_W-1:0] reqData, rspData, hostDq, memDq, lastDq;
    logic              ceN, oeN, weN, resN, hostOe, memOe, doneBusyN;
    logic [10:0]       protMask;
    logic [15:0]       busyNs;
    int                nErrors = 0;
    int                samplesChecked = 0;
    // Released wire shows the inverse of its last level
    wire  [DATA_W-1:0] dqWire = hostOe ? hostDq : (memOe ? memDq : ~lastDq);

    initial lastDq = 8'h00;
    always @(dqWire) if (hostOe || memOe) lastDq = dqWire;

    frc_host #(.BUSY_MAX(100)) DUT (
        .sys_clk(sysClk), .rst_n(rstN), .reqValid(reqValid), .reqOp(reqOp), .reqAddr(reqAddr),
        .reqData(reqData), .reqReady(reqReady), .rspValid(rspValid), .rspData(rspData),
        .rspTimeout(rspTimeout), .flashCeN(ceN), .flashOeN(oeN), .flashWeN(weN), .flashResetN(resN),
        .flashAddr(fAddr), .flashDqOut(hostDq), .flashDqOe(hostOe), .flashDqIn(dqWire),
        .done_busy_n(doneBusyN)
    );

    frc_flash_model #(.MAKER_ID(MK), .DEV_ID(DV), .CONT_ID(CT)) flash (
        .ceN(ceN), .oeN(oeN), .weN(weN), .resetN(resN), .addr(fAddr), .dqIn(dqWire),
        .protMask(protMask), .busyNs(busyNs), .dqOut(memDq), .dqOe(memOe), .doneBusyN(doneBusyN)
    );

    task automatic results();
        $display("errors %0d checks %0d", nErrors, samplesChecked);
        if (nErrors == 0 && samplesChecked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic checkByte(input logic [7:0] exp, input logic [7:0] got);
        samplesChecked++;
        if (got !== exp) begin
            nErrors++;
            $display("unexpected at %0t: expected %h got %h", $time, exp, got);
        end
    endtask

    task automatic checkBit(input logic exp, input logic got);
        checkByte({7'h00, exp}, {7'h00, got});
    endtask

    task automatic doReq(input logic [2:0] op, input logic [ADDR_W-1:0] a, input logic [7:0] d);
        int n;
        n = 0;
        do @(negedge sysClk); while (reqReady !== 1'b1 && ++n < 2000);
        @(posedge sysClk);
        reqOp <= op;
        reqAddr <= a;
        reqData <= d;
        reqValid <= 1'b1;
        @(posedge sysClk);
        reqValid <= 1'b0;
        n = 0;
        do @(negedge sysClk); while (rspValid !== 1'b1 && ++n < 20000);
        checkBit(1'b1, rspValid);
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] exp);
        doReq(FRC_OP_READ, a, 8'h00);
        checkByte(exp, rspData);
    endtask

    task automatic idRd(input logic [ADDR_W-1:0] a, input logic [7:0] exp);
        doReq(FRC_OP_IDRD, a, 8'h00);
        checkByte(exp, rspData);
    endtask

    task automatic testProgram();
        rd(19'h12345, 8'hFF);
        doReq(FRC_OP_PROG, 19'h12345, 8'hA5);
        rd(19'h12345, 8'hA5);
        doReq(FRC_OP_RST, 19'h00000, 8'h00);
        rd(19'h12345, 8'hA5);
    endtask

    task automatic testIdent();
        protMask <= 11'h200;
        idRd(19'h00000, MK);
        idRd(19'h00001, DV);
        idRd(19'h00003, CT);
        idRd(19'h7A002, PROT_YES);
        idRd(19'h78002, PROT_NO);
        idRd(19'h7C002, PROT_NO);
        rd(19'h12345, 8'hA5);
    endtask

    task automatic testProtect();
        doReq(FRC_OP_PROG, 19'h7A010, 8'h3C);
        rd(19'h7A010, 8'hFF);
        protMask <= 11'h000;
        doReq(FRC_OP_PROG, 19'h7A010, 8'h3C);
        rd(19'h7A010, 8'h3C);
        doReq(FRC_OP_PROG, 19'h78000, 8'h11);
        protMask <= 11'h200;
        doReq(FRC_OP_SERA, 19'h7A000, 8'h00);
        rd(19'h7A010, 8'h3C);
        doReq(FRC_OP_SERA, 19'h78000, 8'h00);
        rd(19'h78000, 8'hFF);
        doReq(FRC_OP_CERA, 19'h00000, 8'h00);
        rd(19'h12345, 8'hFF);
        rd(19'h7A010, 8'h3C);
    endtask

    task automatic testAbort();
        busyNs <= 16'd3000;
        doReq(FRC_OP_PROG, 19'h00100, 8'h00);
        checkBit(1'b1, rspTimeout);
        checkBit(1'b0, doneBusyN);
        doReq(FRC_OP_HWRST, 19'h00000, 8'h00);
        checkBit(1'b0, rspTimeout);
        checkBit(1'b1, doneBusyN);
        busyNs <= 16'd300;
        rd(19'h00100, 8'hFF);
        doReq(FRC_OP_PROG, 19'h00100, 8'h00);
        rd(19'h00100, 8'h00);
        doReq(FRC_OP_HWRST, 19'h00000, 8'h00);
        checkBit(1'b0, rspTimeout);
    endtask

    initial begin
        sysClk = 1'b0;
        forever #5 sysClk = ~sysClk;
    end

    initial begin
        #400000;
        nErrors++;
        results();
    end

    initial begin
        rstN = 1'b0;
        reqValid = 1'b0;
        reqOp = 3'h0;
        reqAddr = '0;
        reqData = 8'h00;
        protMask = 11'h000;
        busyNs = 16'd300;
        repeat (16) @(posedge sysClk);
        rstN <= 1'b1;
        testProgram();
        testIdent();
        testProtect();
        testAbort();
        results();
    end
endmodule
`default_nettype wire
